// file: design/free_running_timer_capture.v
// Purpose: 16-bit free-running timer with coherent counter byte reads and an
//          edge-triggered input-capture latch, on an Avalon-MM slave
// Assumes: one clock clk (20 MHz), synchronous active-high reset rst;
//          address is a word index, registers sit in writedata[7:0]
// Notes:   output compare only stores its two bytes; no matching
//          register indexes on the bus:
//            0x12 timer_control   bit 1 capture_edge_select
//            0x13 timer_status    bit 7 capture_flag, bit 5 overflow
//            0x14 capture_high    0x15 capture_low
//            0x16 compare_high    0x17 compare_low
//            0x18 count_high      0x19 count_low
//            0x1A alt_count_high  0x1B alt_count_low
//            0x1C sticky interrupt status, cleared by its read
//            0x1D interrupt mask, same layout as the status
//          interrupt bits: bit 0 overflow, bit 1 capture
//          a full counter wrap takes 262144 clocks
//          software must finish every high/low pair it opens,
//          or the low byte of that pair stays frozen
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "timer_consts.vh"

module free_running_timer_capture #(
   parameter CNT_W = 16
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [4:0]       address,
   input  wire             read,
   input  wire             write,
   input  wire [31:0]      writedata,
   input  wire [3:0]       byteenable,
   output reg  [31:0]      readdata,
   output reg              waitrequest,
   input  wire             capture_input_pin,
   output reg              irq
);

   // true when the bus addresses the given register index
   function hit;
      input [4:0] addr;
      input [4:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // bus handshake: one access per request, answered after one cycle
   wire             access;
   wire             rd;
   wire             wr;
   wire             lane0;

   // timer state
   reg  [2:0]       pre_q;
   reg  [2:0]       pre_d;
   wire             tick;
   reg  [CNT_W-1:0] cnt_q;
   reg  [CNT_W-1:0] cnt_d;
   wire             wrap;

   // coherent read buffers, one per counter pair: 0 main, 1 alternate
   wire [15:0]      pair_buf_w;
   wire [1:0]       pair_lat_w;
   genvar           gp;

   // control, flags and flag-clear arming
   reg  [7:0]       ctl_q;
   reg              ovf_q;
   reg              ovf_arm_q;
   reg              capf_q;
   reg              capf_arm_q;
   reg              cap_hold_q;

   // capture latch, deliberately without reset
   reg  [CNT_W-1:0] cap_q;

   // compare bytes, stored only
   reg  [7:0]       cmp_hi_q;
   reg  [7:0]       cmp_lo_q;

   // interrupt status and mask
   reg  [7:0]       irq_sts_q;
   reg  [7:0]       irq_sts_d;
   reg  [7:0]       irq_msk_q;

   // pin synchroniser, three stages
   reg              pin_s1_q;
   reg              pin_s2_q;
   reg              pin_s3_q;
   // last level that stages two and three agreed on
   reg              pin_lvl_q;
   wire             pin_rise;
   wire             pin_fall;
   wire             cap_edge;

   // read-data mux
   reg  [7:0]       rdata_d;
   wire [7:0]       status_v;

   // bus decode
   assign access = (read | write) & waitrequest;
   assign rd     = read & waitrequest;
   assign wr     = write & waitrequest;
   assign lane0  = byteenable[0];

   // prescaler: fixed divide by four ahead of the counter
   always @* begin
      if (pre_q == `PRESCALE - 3'h1) begin
         pre_d = 3'h0;
      end else begin
         pre_d = pre_q + 3'h1;
      end
   end
   assign tick = (pre_q == `PRESCALE - 3'h1);

   // counter only counts; no bus path ever loads it
   always @* begin
      if (tick) begin
         cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
         cnt_d = cnt_q;
      end
   end
   assign wrap = tick & (cnt_q == `CNT_MAX);

   always @(posedge clk) begin
      if (rst) begin
         pre_q <= 3'h0;
         cnt_q <= `CNT_RESET;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
      end
   end

   // capture pin: three stages; a level counts once stages two and
   // three agree, so a metastable first stage never makes an edge;
   // the level resets low, so a pin held high through reset gives
   // one rising edge after release
   always @(posedge clk) begin
      if (rst) begin
         pin_s1_q  <= 1'b0;
         pin_s2_q  <= 1'b0;
         pin_s3_q  <= 1'b0;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_s1_q <= capture_input_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q == pin_s3_q) begin
            pin_lvl_q <= pin_s3_q;
         end
      end
   end
   // an edge is an agreed level that differs from the last one
   assign pin_rise = pin_s2_q & pin_s3_q & ~pin_lvl_q;
   assign pin_fall = ~pin_s2_q & ~pin_s3_q & pin_lvl_q;
   // edge select bit: 1 rising, 0 falling
   assign cap_edge = ctl_q[`CTL_EDGE_BIT] ? pin_rise : pin_fall;

   // capture latch: loads on every selected edge unless a high-byte read holds it
   always @(posedge clk) begin
      if (cap_edge && !cap_hold_q) begin
         cap_q <= cnt_q;
      end
   end

   // a capture high read freezes the latch until its low byte is read or written
   always @(posedge clk) begin
      if (rst) begin
         cap_hold_q <= 1'b0;
      end else if (rd && hit(address, `OFS_CAP_HIGH)) begin
         cap_hold_q <= 1'b1;
      end else if (access && hit(address, `OFS_CAP_LOW)) begin
         cap_hold_q <= 1'b0;
      end
   end

   // pair buffers: first high read freezes the low byte; separate
   // state per pair so a plain alternate read never opens the main one
   generate
      for (gp = 0; gp < 2; gp = gp + 1) begin : g_pair
         reg  [7:0] buf_q;
         reg        lat_q;
         wire [4:0] hi_ofs;
         assign hi_ofs = (gp == 0) ? `OFS_CNT_HIGH : `OFS_ALT_HIGH;
         always @(posedge clk) begin
            if (rst) begin
               lat_q <= 1'b0;
               buf_q <= 8'h00;
            end else if (rd && hit(address, hi_ofs)) begin
               if (!lat_q) begin
                  buf_q <= cnt_q[7:0];
               end
               lat_q <= 1'b1;
            end else if (rd && hit(address, hi_ofs + 5'h01)) begin
               lat_q <= 1'b0;
            end
         end
         assign pair_buf_w[gp*8 +: 8] = buf_q;
         assign pair_lat_w[gp]        = lat_q;
      end
   endgenerate

   // overflow flag: status read with flag set arms, main low read clears;
   // alternate reads never touch it, so they suit plain time reads
   always @(posedge clk) begin
      if (rst) begin
         ovf_q     <= 1'b0;
         ovf_arm_q <= 1'b0;
      end else begin
         if (wrap) begin
            ovf_q <= 1'b1;
         end else if (ovf_arm_q && rd && hit(address, `OFS_CNT_LOW)) begin
            ovf_q <= 1'b0;
         end
         if (rd && hit(address, `OFS_STATUS) && ovf_q) begin
            ovf_arm_q <= 1'b1;
         end else if (rd && hit(address, `OFS_CNT_LOW)) begin
            ovf_arm_q <= 1'b0;
         end
      end
   end

   // capture flag: set wins over the status-then-low-byte clear
   always @(posedge clk) begin
      if (rst) begin
         capf_q     <= 1'b0;
         capf_arm_q <= 1'b0;
      end else begin
         if (cap_edge && !cap_hold_q) begin
            capf_q <= 1'b1;
         end else if (capf_arm_q && access
                      && hit(address, `OFS_CAP_LOW)) begin
            capf_q <= 1'b0;
         end
         if (rd && hit(address, `OFS_STATUS) && capf_q) begin
            capf_arm_q <= 1'b1;
         end else if (access && hit(address, `OFS_CAP_LOW)) begin
            capf_arm_q <= 1'b0;
         end
      end
   end

   // timer_control; counter and status writes reach no register
   always @(posedge clk) begin
      if (rst) begin
         ctl_q <= `CTL_RESET;
      end else if (wr && lane0 && hit(address, `OFS_CONTROL)) begin
         ctl_q <= writedata[7:0];
      end
   end

   // interrupt mask, same layout as the sticky status
   always @(posedge clk) begin
      if (rst) begin
         irq_msk_q <= `IRQ_RESET;
      end else if (wr && lane0 && hit(address, `OFS_IRQ_MASK)) begin
         irq_msk_q <= writedata[7:0];
      end
   end

   // compare high byte: storage only, no matching behind it
   always @(posedge clk) begin
      if (rst) begin
         cmp_hi_q <= 8'h00;
      end else if (wr && lane0 && hit(address, `OFS_CMP_HIGH)) begin
         cmp_hi_q <= writedata[7:0];
      end
   end

   // compare low byte: storage only
   always @(posedge clk) begin
      if (rst) begin
         cmp_lo_q <= 8'h00;
      end else if (wr && lane0 && hit(address, `OFS_CMP_LOW)) begin
         cmp_lo_q <= writedata[7:0];
      end
   end

   // sticky interrupt status: a read clears, a new event wins
   always @* begin
      irq_sts_d = irq_sts_q;
      if (rd && hit(address, `OFS_IRQ_STATUS)) begin
         irq_sts_d = 8'h00;
      end
      if (wrap) begin
         irq_sts_d[`IRQ_OVF_BIT] = 1'b1;
      end
      if (cap_edge && !cap_hold_q) begin
         irq_sts_d[`IRQ_CAP_BIT] = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         irq_sts_q <= `IRQ_RESET;
         irq       <= 1'b0;
      end else begin
         irq_sts_q <= irq_sts_d;
         irq       <= |(irq_sts_d & irq_msk_q);
      end
   end

   // timer status view
   assign status_v = {capf_q, 1'b0, ovf_q, 5'h00};

   // read mux; counter low bytes return the buffer while a sequence is open
   always @* begin
      case (address)
         `OFS_CONTROL:    rdata_d = ctl_q;
         `OFS_STATUS:     rdata_d = status_v;
         `OFS_CAP_HIGH:   rdata_d = cap_q[15:8];
         `OFS_CAP_LOW:    rdata_d = cap_q[7:0];
         `OFS_CMP_HIGH:   rdata_d = cmp_hi_q;
         `OFS_CMP_LOW:    rdata_d = cmp_lo_q;
         `OFS_CNT_HIGH:   rdata_d = cnt_q[15:8];
         `OFS_CNT_LOW:
            rdata_d = pair_lat_w[0] ? pair_buf_w[7:0] : cnt_q[7:0];
         `OFS_ALT_HIGH:   rdata_d = cnt_q[15:8];
         `OFS_ALT_LOW:
            rdata_d = pair_lat_w[1] ? pair_buf_w[15:8] : cnt_q[7:0];
         `OFS_IRQ_STATUS: rdata_d = irq_sts_q;
         `OFS_IRQ_MASK:   rdata_d = irq_msk_q;
         default:         rdata_d = 8'h00;
      endcase
   end

   // handshake: waitrequest drops for exactly one cycle per request;
   // all side effects fire once, at the edge that drops it
   always @(posedge clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
      end else if (access) begin
         waitrequest <= 1'b0;
         if (read) begin
            readdata <= {24'h000000, rdata_d};
         end
      end else begin
         waitrequest <= 1'b1;
      end
   end

endmodule // free_running_timer_capture

// file: pkg/timer_consts.vh
// Purpose: constants for the free-running timer with input capture
// Assumes: word-indexed Avalon-MM slave, 8-bit registers in low bits
// Notes:   offsets are register indexes; byte address is four times them
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// register indexes
`define OFS_CONTROL     5'h12
`define OFS_STATUS      5'h13
`define OFS_CAP_HIGH    5'h14
`define OFS_CAP_LOW     5'h15
`define OFS_CMP_HIGH    5'h16
`define OFS_CMP_LOW     5'h17
`define OFS_CNT_HIGH    5'h18
`define OFS_CNT_LOW     5'h19
`define OFS_ALT_HIGH    5'h1A
`define OFS_ALT_LOW     5'h1B
`define OFS_IRQ_STATUS  5'h1C
`define OFS_IRQ_MASK    5'h1D

// timer_control fields
`define CTL_EDGE_BIT    1
`define CTL_RESET       8'h00

// timer_status fields
`define STS_CAP_BIT     7
`define STS_OVF_BIT     5

// interrupt status / mask fields
`define IRQ_OVF_BIT     0
`define IRQ_CAP_BIT     1
`define IRQ_RESET       8'h00

// prescaler: counter advances once per this many clocks
`define PRESCALE        3'h4
`define CNT_RESET       16'h0000
`define CNT_MAX         16'hFFFF

`endif

// file: sim/frtc_chk.sv
// Purpose: port assertions for free_running_timer_capture
// Assumes: one clock, synchronous active-high reset
// Notes:   control and mask shadows rebuilt from taken bus writes
`timescale 1ns/100ps
`include "timer_consts.vh"
module frtc_chk #(
   parameter CNT_W = 16
) (
   input wire        clk,
   input wire        rst,
   input wire [4:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire [3:0]  byteenable,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire        capture_input_pin,
   input wire        irq
);
   reg  [7:0] ctl_q;
   reg  [7:0] msk_q;
   wire       tk = (read | write) & waitrequest;
   wire       rd = tk & read;
   // shadows only follow writes with byte lane 0 enabled
   always @(posedge clk) begin
      if (rst) begin
         ctl_q <= 8'h00;
         msk_q <= 8'h00;
      end else if (tk & write & byteenable[0]) begin
         if (address == `OFS_CONTROL) ctl_q <= writedata[7:0];
         if (address == `OFS_IRQ_MASK) msk_q <= writedata[7:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   answer_next_a: assert property (tk |=> !waitrequest)
      else $error("request not answered next cycle");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   reset_idle_a: assert property (disable iff (1'b0)
      rst |=> waitrequest && !irq && readdata == 32'h0)
      else $error("outputs not idle after reset");
   unmapped_zero_a: assert property (rd && address == 5'h00 |=> readdata == 0)
      else $error("unmapped read not zero");
   status_bits_a: assert property (rd && address == `OFS_STATUS
      |=> (readdata[7:0] & 8'h5F) == 8'h00)
      else $error("unused status bits set");
   edge_sel_a: assert property (rd && address == `OFS_CONTROL
      |=> readdata[7:0] == ctl_q)
      else $error("control readback wrong");
   irq_masked_a: assert property (msk_q == 8'h00 && $past(msk_q) == 8'h00
      |-> !irq)
      else $error("interrupt while fully masked");
endmodule // frtc_chk
bind free_running_timer_capture frtc_chk #(.CNT_W(CNT_W)) u_chk (
   .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .capture_input_pin(capture_input_pin),
   .irq(irq));

// file: sim/tb_free_running_timer_capture.sv
// Purpose: self-checking bench for free_running_timer_capture
// Assumes: bus answers after one cycle; capture pin passes 3 flops
// Notes:   a counter wrap needs 262144 clocks, so overflow is not run
`timescale 1ns/100ps
`include "timer_consts.vh"
`define CHK(nm, e, g) begin n_checks = n_checks + 1; \
   if ((g) !== (e)) begin bad_count = bad_count + 1; \
   $display("[ERR] %s exp %h seen %h", nm, e, g); end end
module tb_free_running_timer_capture;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [4:0]  address = 5'h00;
   reg         read = 1'b0;
   reg         write = 1'b0;
   reg  [31:0] writedata = 32'h0;
   reg  [3:0]  byteenable = 4'h1;
   reg         pin = 1'b0;
   wire [31:0] readdata;
   wire        waitrequest;
   wire        irq;
   integer     bad_count = 0;
   integer     n_checks = 0;
   integer     cyc = 0;
   integer     i;
   reg  [7:0]  r, a, c, d;
   reg  [4:0]  hi;
   free_running_timer_capture #(.CNT_W(16)) u_dut (
      .clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .capture_input_pin(pin), .irq(irq));
   // 50 ns bench clock
   initial begin
      forever #25 clk = ~clk;
   end
   // hang guard, far above the run length
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // one bus cycle; an idle edge after it so no strobe toggles twice
   // a hung slave is ended by the hang guard alone
   task xfer(input w, input [4:0] ad, input [7:0] wd);
      begin
         address <= ad;
         write <= w;
         read <= !w;
         writedata <= {24'h0, wd};
         @(posedge clk);
         while (waitrequest !== 1'b0) begin
            @(posedge clk);
         end
         r = readdata[7:0];
         read <= 1'b0;
         write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [4:0] ad);
      xfer(1'b0, ad, 8'h00);
   endtask
   // note live count, then move the pin and let the synchroniser settle
   task edge_at(input v);
      begin
         rd(`OFS_ALT_LOW);
         a = r;
         pin <= v;
         repeat (8) @(posedge clk);
      end
   endtask
   task t_count;
      begin
         rd(`OFS_CNT_LOW);
         `CHK("count at reset", 8'h00, r)
         repeat (37) @(posedge clk);
         rd(`OFS_CNT_LOW);
         a = r;
         `CHK("ticks per 40", 8'h0A, a)
         xfer(1'b1, `OFS_CNT_LOW, 8'hAA);
         xfer(1'b1, `OFS_CNT_HIGH, 8'hAA);
         repeat (3) @(posedge clk);
         rd(`OFS_CNT_LOW);
         d = r - a;
         `CHK("writes ignored", 8'h03, d)
         rd(5'h00);
         `CHK("unmapped", 8'h00, r)
         for (i = 0; i < 2; i = i + 1) begin
            hi = i ? `OFS_ALT_HIGH : `OFS_CNT_HIGH;
            rd(hi + 5'h01);
            a = r;
            rd(hi);
            repeat (37) @(posedge clk);
            rd(hi);
            rd(hi + 5'h01);
            d = r - a;
            `CHK("buffered low", 1'b1, d <= 8'h01)
         end
         $display("t_count done");
      end
   endtask
   task t_capture;
      begin
         xfer(1'b1, `OFS_CONTROL, 8'h02);
         xfer(1'b1, `OFS_IRQ_MASK, 8'h02);
         edge_at(1'b1);
         `CHK("irq raised", 1'b1, irq)
         rd(`OFS_STATUS);
         `CHK("flag set", 1'b1, r[`STS_CAP_BIT])
         rd(`OFS_CAP_HIGH);
         rd(`OFS_CAP_LOW);
         c = r;
         d = c - a;
         `CHK("rise captured", 1'b1, d <= 8'h02)
         rd(`OFS_STATUS);
         `CHK("flag cleared", 1'b0, r[`STS_CAP_BIT])
         rd(`OFS_IRQ_STATUS);
         repeat (2) @(posedge clk);
         `CHK("irq cleared", 1'b0, irq)
         edge_at(1'b0);
         rd(`OFS_CAP_LOW);
         `CHK("fall ignored", c, r)
         xfer(1'b1, `OFS_CONTROL, 8'h00);
         edge_at(1'b1);
         edge_at(1'b0);
         rd(`OFS_CAP_LOW);
         d = r - a;
         `CHK("fall captured", 1'b1, d <= 8'h02)
         rd(`OFS_STATUS);
         `CHK("flag kept", 1'b1, r[`STS_CAP_BIT])
         edge_at(1'b1);
         edge_at(1'b0);
         c = a;
         rd(`OFS_CAP_HIGH);
         edge_at(1'b1);
         edge_at(1'b0);
         rd(`OFS_CAP_LOW);
         d = r - c;
         `CHK("recapture held", 1'b1, d <= 8'h02)
         xfer(1'b1, `OFS_IRQ_MASK, 8'h00);
         repeat (2) @(posedge clk);
         `CHK("irq masked", 1'b0, irq)
         $display("t_capture done");
      end
   endtask
   // reset for four edges, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_count;
      t_capture;
      close_out;
   end
endmodule // tb_free_running_timer_capture
